/* include/fcsms_pkg.sv */
// Constants, types and state layout of the flow-control safe mode supervisor
// Functional notes
// - Any set bit in the error status word forces Safe Mode.
// - No active cyclic connection, including after close or timeout, forces Safe Mode.
// - Active connection with run/idle flag at Idle keeps Safe Mode.
// - Run flag from the master selects the executing state.
// - Controller in Safe Mode halts flow control and forces the valve to safe state.
// - Safe-state code: 0 close, 1 open, 2 hold, 3 configured safe value.
// - Safe-state setting resets to the close code.
// - Calibration instance stays within 1 to configured count; resets to 1.
// - Calibration selection comes from output assembly 101 (controller) or 102 (meter).
// - A zero calibration selection in cyclic data is ignored.
// - Out-of-range selection keeps calibration and sets invalid-calibration alarm.
// - Any invalid configuration field rejects the data and the connection.
// - Alarm mask resets to all zeros.
// - Warning mask resets to all zeros.
// - Flow unit codes reset to 0x1007, temperature unit to 0x1200.
package fcsms_pkg;
    // Register byte addresses
    localparam logic [7:0] FCSMS_A_CTRL = 8'h00;
    localparam logic [7:0] FCSMS_A_SAFE_VAL = 8'h04;
    localparam logic [7:0] FCSMS_A_CAL = 8'h08;
    localparam logic [7:0] FCSMS_A_NUM_CAL = 8'h0C;
    localparam logic [7:0] FCSMS_A_ALARM_MASK = 8'h10;
    localparam logic [7:0] FCSMS_A_WARN_MASK = 8'h14;
    localparam logic [7:0] FCSMS_A_FLOW_UNIT = 8'h18;
    localparam logic [7:0] FCSMS_A_CTRL_UNIT = 8'h1C;
    localparam logic [7:0] FCSMS_A_TEMP_UNIT = 8'h20;
    localparam logic [7:0] FCSMS_A_STATUS = 8'h24;
    localparam logic [7:0] FCSMS_A_IRQ_STAT = 8'h28;
    localparam logic [7:0] FCSMS_A_IRQ_MASK = 8'h2C;
    localparam logic [7:0] FCSMS_A_ERR = 8'h30;
    localparam logic [7:0] FCSMS_A_ALARM = 8'h34;
    // Field positions
    localparam int FCSMS_CTRL_VARIANT = 0;
    localparam int FCSMS_CTRL_SAFE_LSB = 1;
    localparam int FCSMS_ALARM_BAD_CAL = 0;
    localparam int FCSMS_IRQ_ENTER_SAFE = 0;
    localparam int FCSMS_IRQ_LEAVE_SAFE = 1;
    localparam int FCSMS_IRQ_CONN_REJ = 2;
    localparam int FCSMS_IRQ_BAD_CAL = 3;
    localparam int FCSMS_IRQ_W = 4;
    // Assembly identifiers and configuration size
    localparam logic [15:0] FCSMS_ASM_OUT_CTRL = 16'd101;
    localparam logic [15:0] FCSMS_ASM_OUT_METER = 16'd102;
    localparam logic [15:0] FCSMS_ASM_CFG = 16'd100;
    localparam logic [15:0] FCSMS_ASM_NONE = 16'd0;
    localparam logic [15:0] FCSMS_CFG_LEN = 16'd180;
    localparam logic [15:0] FCSMS_CFG_LEN_NONE = 16'd0;
    // Accepted range of engineering unit codes
    localparam logic [31:0] FCSMS_UNIT_MIN = 32'h0000_1000;
    localparam logic [31:0] FCSMS_UNIT_MAX = 32'h0000_1FFF;
    // Reset values
    localparam logic [15:0] FCSMS_RST_FLOW_UNIT = 16'h1007;
    localparam logic [15:0] FCSMS_RST_TEMP_UNIT = 16'h1200;
    localparam logic [31:0] FCSMS_RST_CAL = 32'h0000_0001;
    localparam logic [31:0] FCSMS_RST_NUM_CAL = 32'h0000_0001;
    localparam logic [31:0] FCSMS_RST_MASK = 32'h0000_0000;
    localparam logic [15:0] FCSMS_RST_SAFE_VAL = 16'h0000;
    localparam logic FCSMS_RST_VARIANT = 1'b1;
    // Valve drive levels
    localparam logic [15:0] FCSMS_VALVE_CLOSED = 16'h0000;
    localparam logic [15:0] FCSMS_VALVE_OPEN = 16'hFFFF;

    typedef enum logic [1:0] {
        FCSMS_SAFE_CLOSE = 2'h0,
        FCSMS_SAFE_OPEN = 2'h1,
        FCSMS_SAFE_HOLD = 2'h2,
        FCSMS_SAFE_VALUE = 2'h3
    } fcsms_safe_t;

    typedef enum logic [1:0] {
        FCSMS_ST_SAFE = 2'b00,
        FCSMS_ST_EXEC = 2'b01
    } fcsms_mode_t;

    // Connection-open request with the configuration fields checked here
    typedef struct packed {
        logic req;
        logic [15:0] asm_id;
        logic [15:0] len;
        logic [31:0] flow_unit;
        logic [31:0] cal;
        logic [31:0] safe_state;
    } fcsms_open_t;

    // One received cyclic output message
    typedef struct packed {
        logic valid;
        logic [15:0] asm_id;
        logic run;
        logic [31:0] cal_sel;
    } fcsms_cyc_t;

    typedef struct packed {
        logic variant;
        fcsms_safe_t safe_sel;
        logic [15:0] safe_val;
        logic [31:0] cal;
        logic [31:0] num_cal;
        logic [31:0] alarm_mask;
        logic [31:0] warn_mask;
        logic [15:0] flow_unit;
        logic [15:0] ctrl_unit;
        logic [15:0] temp_unit;
        logic [31:0] alarm_st;
        logic [FCSMS_IRQ_W-1:0] irq_st;
        logic [FCSMS_IRQ_W-1:0] irq_mask;
        logic conn;
        logic run;
        fcsms_mode_t mode;
        logic valve_force;
        logic [15:0] valve_cmd;
        logic accept;
        logic reject;
        logic [31:0] rdata;
    } fcsms_state_t;
endpackage

/* hw/fcsms_cfg_check.sv */
// Validation of configuration data carried by a connection-open request
module fcsms_cfg_check (
    input fcsms_pkg::fcsms_open_t open_req,
    input logic [31:0] num_cal,
    output logic cfg_ok,
    output logic cfg_has_data
);
    import fcsms_pkg::*;

    logic none_ok;
    logic unit_ok;
    logic cal_ok;
    logic safe_ok;
    logic data_ok;

    assign none_ok = (open_req.asm_id == FCSMS_ASM_NONE) && (open_req.len == FCSMS_CFG_LEN_NONE);
    assign unit_ok = (open_req.flow_unit >= FCSMS_UNIT_MIN) && (open_req.flow_unit <= FCSMS_UNIT_MAX);
    assign cal_ok = (open_req.cal != 32'h0000_0000) && (open_req.cal <= num_cal);
    assign safe_ok = open_req.safe_state <= 32'h0000_0003;
    assign data_ok = (open_req.asm_id == FCSMS_ASM_CFG) && (open_req.len == FCSMS_CFG_LEN)
                     && unit_ok && cal_ok && safe_ok;
    assign cfg_ok = none_ok || data_ok;
    assign cfg_has_data = data_ok;
endmodule

/* hw/fcsms_top.sv */
// Safe mode supervisor: connection tracking, valve safe state, calibration select, registers
module fcsms_top (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [31:0] err_status,
    input wire logic [31:0] warn_status,
    input wire logic [15:0] valve_pos,
    input fcsms_pkg::fcsms_open_t conn_open,
    input wire logic conn_close,
    input wire logic conn_timeout,
    input fcsms_pkg::fcsms_cyc_t cyc,
    output logic conn_accept,
    output logic conn_reject,
    output logic safe_mode,
    output logic ctrl_run,
    output logic valve_force,
    output logic [15:0] valve_cmd,
    output logic [31:0] active_cal,
    output logic [15:0] flow_unit,
    output logic [15:0] ctrl_unit,
    output logic [15:0] temp_unit,
    output logic alarm,
    output logic warning,
    output logic irq
);
    import fcsms_pkg::*;

    fcsms_state_t s_q;
    fcsms_state_t s_d;

    logic cfg_ok;
    logic cfg_has_data;
    logic safe_cond;
    logic [15:0] out_asm;
    logic [FCSMS_IRQ_W-1:0] ev;

    fcsms_cfg_check u_cfg_check (
        .open_req(conn_open),
        .num_cal(s_q.num_cal),
        .cfg_ok(cfg_ok),
        .cfg_has_data(cfg_has_data)
    );

    function automatic logic cal_in_range(input logic [31:0] sel, input logic [31:0] limit);
        cal_in_range = (sel != 32'h0000_0000) && (sel <= limit);
    endfunction

    function automatic logic [31:0] read_reg(input logic [7:0] a, input fcsms_state_t s,
                                             input logic [31:0] err);
        read_reg = 32'h0000_0000;
        unique case (a)
            FCSMS_A_CTRL: begin
                read_reg[FCSMS_CTRL_VARIANT] = s.variant;
                read_reg[FCSMS_CTRL_SAFE_LSB +: 2] = s.safe_sel;
            end
            FCSMS_A_SAFE_VAL: begin
                read_reg[15:0] = s.safe_val;
            end
            FCSMS_A_CAL: begin
                read_reg = s.cal;
            end
            FCSMS_A_NUM_CAL: begin
                read_reg = s.num_cal;
            end
            FCSMS_A_ALARM_MASK: begin
                read_reg = s.alarm_mask;
            end
            FCSMS_A_WARN_MASK: begin
                read_reg = s.warn_mask;
            end
            FCSMS_A_FLOW_UNIT: begin
                read_reg[15:0] = s.flow_unit;
            end
            FCSMS_A_CTRL_UNIT: begin
                read_reg[15:0] = s.ctrl_unit;
            end
            FCSMS_A_TEMP_UNIT: begin
                read_reg[15:0] = s.temp_unit;
            end
            FCSMS_A_STATUS: begin
                read_reg[3:0] = {s.mode == FCSMS_ST_SAFE, s.valve_force, s.run, s.conn};
            end
            FCSMS_A_IRQ_STAT: begin
                read_reg[FCSMS_IRQ_W-1:0] = s.irq_st;
            end
            FCSMS_A_IRQ_MASK: begin
                read_reg[FCSMS_IRQ_W-1:0] = s.irq_mask;
            end
            FCSMS_A_ERR: begin
                read_reg = err;
            end
            FCSMS_A_ALARM: begin
                read_reg = s.alarm_st;
            end
            default: begin
                read_reg = 32'h0000_0000;
            end
        endcase
    endfunction

    // output assembly that carries the calibration field
    assign out_asm = s_q.variant ? FCSMS_ASM_OUT_CTRL : FCSMS_ASM_OUT_METER;

    assign safe_cond = (|err_status) || !s_q.conn || !s_q.run;

    always_comb begin
        s_d = s_q;
        ev = '0;
        s_d.accept = 1'b0;
        s_d.reject = 1'b0;
        s_d.rdata = 32'h0000_0000;

        // close or timeout ends the connection
        if (conn_close || conn_timeout) begin
            s_d.conn = 1'b0;
            s_d.run = 1'b0;
        end

        // refuse the open on bad data or when already owned
        if (conn_open.req) begin
            if (!s_q.conn && cfg_ok) begin
                s_d.conn = 1'b1;
                s_d.run = 1'b0;
                s_d.accept = 1'b1;
                if (cfg_has_data) begin
                    s_d.flow_unit = conn_open.flow_unit[15:0];
                    s_d.cal = conn_open.cal;
                    s_d.safe_sel = fcsms_safe_t'(conn_open.safe_state[1:0]);
                end
            end else begin
                s_d.reject = 1'b1;
                ev[FCSMS_IRQ_CONN_REJ] = 1'b1;
            end
        end

        // run/idle flag from each cyclic message while connected and not closing or timing out
        if (cyc.valid && s_q.conn && !conn_close && !conn_timeout) begin
            s_d.run = cyc.run;
            if ((cyc.asm_id == out_asm) && (cyc.cal_sel != 32'h0000_0000)) begin
                if (cal_in_range(cyc.cal_sel, s_q.num_cal)) begin
                    s_d.cal = cyc.cal_sel;
                end else begin
                    ev[FCSMS_IRQ_BAD_CAL] = 1'b1;
                end
            end
        end

        if (wr) begin
            unique case (addr)
                FCSMS_A_CTRL: begin
                    s_d.variant = wdata[FCSMS_CTRL_VARIANT];
                    s_d.safe_sel = fcsms_safe_t'(wdata[FCSMS_CTRL_SAFE_LSB +: 2]);
                end
                FCSMS_A_SAFE_VAL: begin
                    s_d.safe_val = wdata[15:0];
                end
                FCSMS_A_CAL: begin
                    if (cal_in_range(wdata, s_q.num_cal)) begin
                        s_d.cal = wdata;
                    end else begin
                        ev[FCSMS_IRQ_BAD_CAL] = 1'b1;
                    end
                end
                FCSMS_A_NUM_CAL: begin
                    if (wdata != 32'h0000_0000) begin
                        s_d.num_cal = wdata;
                        if (s_d.cal > wdata) begin
                            s_d.cal = wdata;
                        end
                    end
                end
                FCSMS_A_ALARM_MASK: begin
                    s_d.alarm_mask = wdata;
                end
                FCSMS_A_WARN_MASK: begin
                    s_d.warn_mask = wdata;
                end
                FCSMS_A_FLOW_UNIT: begin
                    s_d.flow_unit = wdata[15:0];
                end
                FCSMS_A_CTRL_UNIT: begin
                    s_d.ctrl_unit = wdata[15:0];
                end
                FCSMS_A_TEMP_UNIT: begin
                    s_d.temp_unit = wdata[15:0];
                end
                FCSMS_A_IRQ_STAT: begin
                    s_d.irq_st = s_q.irq_st & ~wdata[FCSMS_IRQ_W-1:0];
                end
                FCSMS_A_IRQ_MASK: begin
                    s_d.irq_mask = wdata[FCSMS_IRQ_W-1:0];
                end
                FCSMS_A_ALARM: begin
                    s_d.alarm_st = s_q.alarm_st & ~wdata;
                end
                default: begin
                end
            endcase
        end

        // execution only when every safe condition is gone
        unique case (s_q.mode)
            FCSMS_ST_SAFE: begin
                if (!safe_cond) begin
                    s_d.mode = FCSMS_ST_EXEC;
                    ev[FCSMS_IRQ_LEAVE_SAFE] = 1'b1;
                end
            end
            FCSMS_ST_EXEC: begin
                if (safe_cond) begin
                    s_d.mode = FCSMS_ST_SAFE;
                    ev[FCSMS_IRQ_ENTER_SAFE] = 1'b1;
                end
            end
            default: begin
                s_d.mode = FCSMS_ST_SAFE;
            end
        endcase

        // controller forces the valve while in Safe Mode
        s_d.valve_force = s_q.variant && (s_d.mode == FCSMS_ST_SAFE);
        if (s_d.mode == FCSMS_ST_EXEC) begin
            s_d.valve_cmd = valve_pos;
        end else begin
            unique case (s_q.safe_sel)
                FCSMS_SAFE_CLOSE: begin
                    s_d.valve_cmd = FCSMS_VALVE_CLOSED;
                end
                FCSMS_SAFE_OPEN: begin
                    s_d.valve_cmd = FCSMS_VALVE_OPEN;
                end
                FCSMS_SAFE_HOLD: begin
                    s_d.valve_cmd = s_q.valve_cmd;
                end
                FCSMS_SAFE_VALUE: begin
                    s_d.valve_cmd = s_q.safe_val;
                end
            endcase
        end

        // Events set after the clear so a same-cycle event survives
        if (ev[FCSMS_IRQ_BAD_CAL]) begin
            s_d.alarm_st[FCSMS_ALARM_BAD_CAL] = 1'b1;
        end
        s_d.irq_st = s_d.irq_st | ev;

        if (rd) begin
            s_d.rdata = read_reg(addr, s_q, err_status);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_q.variant <= FCSMS_RST_VARIANT;
            s_q.safe_sel <= FCSMS_SAFE_CLOSE;
            s_q.safe_val <= FCSMS_RST_SAFE_VAL;
            s_q.cal <= FCSMS_RST_CAL;
            s_q.num_cal <= FCSMS_RST_NUM_CAL;
            s_q.alarm_mask <= FCSMS_RST_MASK;
            s_q.warn_mask <= FCSMS_RST_MASK;
            s_q.flow_unit <= FCSMS_RST_FLOW_UNIT;
            s_q.ctrl_unit <= FCSMS_RST_FLOW_UNIT;
            s_q.temp_unit <= FCSMS_RST_TEMP_UNIT;
            s_q.alarm_st <= 32'h0000_0000;
            s_q.irq_st <= '0;
            s_q.irq_mask <= '0;
            s_q.conn <= 1'b0;
            s_q.run <= 1'b0;
            s_q.mode <= FCSMS_ST_SAFE;
            s_q.valve_force <= FCSMS_RST_VARIANT;
            s_q.valve_cmd <= FCSMS_VALVE_CLOSED;
            s_q.accept <= 1'b0;
            s_q.reject <= 1'b0;
            s_q.rdata <= 32'h0000_0000;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rdata;
    assign conn_accept = s_q.accept;
    assign conn_reject = s_q.reject;
    assign safe_mode = s_q.mode == FCSMS_ST_SAFE;
    assign ctrl_run = s_q.variant && (s_q.mode == FCSMS_ST_EXEC);
    assign valve_force = s_q.valve_force;
    assign valve_cmd = s_q.valve_cmd;
    assign active_cal = s_q.cal;
    assign flow_unit = s_q.flow_unit;
    assign ctrl_unit = s_q.ctrl_unit;
    assign temp_unit = s_q.temp_unit;
    assign alarm = |(s_q.alarm_st & s_q.alarm_mask);
    assign warning = |(warn_status & s_q.warn_mask);
    assign irq = |(s_q.irq_st & s_q.irq_mask);
endmodule

/* test/fcsms_props.sv */
// Port checker for the safe mode supervisor, bound to its top module
module fcsms_props (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic wr,
    input wire logic [31:0] err_status,
    input fcsms_pkg::fcsms_open_t conn_open,
    input wire logic conn_close,
    input wire logic conn_timeout,
    input fcsms_pkg::fcsms_cyc_t cyc,
    input wire logic conn_accept,
    input wire logic conn_reject,
    input wire logic safe_mode,
    input wire logic ctrl_run,
    input wire logic valve_force,
    input wire logic [15:0] valve_cmd,
    input wire logic [31:0] active_cal,
    input wire logic [15:0] flow_unit,
    input wire logic [15:0] ctrl_unit,
    input wire logic [15:0] temp_unit,
    input wire logic alarm,
    input wire logic warning
);
    timeunit 1ns;
    timeprecision 1ns;
    import fcsms_pkg::*;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    property p_err_safe; err_status != 32'h0 |=> safe_mode; endproperty
    a_err_safe: assert property (p_err_safe) else $error("no safe mode on error");
    property p_drop_safe; (conn_close || conn_timeout) && !conn_open.req |-> ##2 safe_mode; endproperty
    a_drop_safe: assert property (p_drop_safe) else $error("no safe mode after drop");
    property p_idle_safe; cyc.valid && !cyc.run |-> ##2 safe_mode; endproperty
    a_idle_safe: assert property (p_idle_safe) else $error("no safe mode on idle");
    property p_exec_ok; !safe_mode |-> $past(err_status) == 32'h0; endproperty
    a_exec_ok: assert property (p_exec_ok) else $error("executing with error set");
    property p_force; $rose(safe_mode) && $past(ctrl_run) |-> valve_force && !ctrl_run; endproperty
    a_force: assert property (p_force) else $error("valve not forced in safe mode");
    property p_one_answer; conn_open.req |=> conn_accept != conn_reject; endproperty
    a_one_answer: assert property (p_one_answer) else $error("open not answered once");
    property p_bad_safe;
        conn_open.req && conn_open.asm_id == FCSMS_ASM_CFG && conn_open.safe_state > 32'h3 |=> conn_reject;
    endproperty
    a_bad_safe: assert property (p_bad_safe) else $error("bad safe state accepted");
    property p_zero_cal; cyc.valid && cyc.cal_sel == 32'h0 && !wr && !conn_open.req |=> $stable(active_cal); endproperty
    a_zero_cal: assert property (p_zero_cal) else $error("zero selection changed cal");
    property p_rst_units;
        $rose(rst_b) |-> flow_unit == 16'h1007 && ctrl_unit == 16'h1007 && temp_unit == 16'h1200;
    endproperty
    a_rst_units: assert property (p_rst_units) else $error("unit codes wrong after reset");
    property p_rst_safe;
        $rose(rst_b) |-> safe_mode && valve_cmd == 16'h0000 && active_cal == 32'h1 && !alarm && !warning;
    endproperty
    a_rst_safe: assert property (p_rst_safe) else $error("state wrong after reset");
    c_accept: cover property (conn_accept);
    c_reject: cover property (conn_reject);
    c_exec: cover property ($fell(safe_mode));
endmodule

bind fcsms_top fcsms_props u_props (.mclk(mclk), .rst_b(rst_b), .wr(wr), .err_status(err_status),
    .conn_open(conn_open), .conn_close(conn_close), .conn_timeout(conn_timeout), .cyc(cyc),
    .conn_accept(conn_accept), .conn_reject(conn_reject), .safe_mode(safe_mode), .ctrl_run(ctrl_run),
    .valve_force(valve_force), .valve_cmd(valve_cmd), .active_cal(active_cal), .flow_unit(flow_unit),
    .ctrl_unit(ctrl_unit), .temp_unit(temp_unit), .alarm(alarm), .warning(warning));

/* test/fcsms_master.sv */
// Behavioural network master: connection open, cyclic messages, close and timeout
module fcsms_master (
    input wire logic mclk,
    output fcsms_pkg::fcsms_open_t conn_open,
    output logic conn_close,
    output logic conn_timeout,
    output fcsms_pkg::fcsms_cyc_t cyc
);
    timeunit 1ns;
    timeprecision 1ns;
    import fcsms_pkg::*;
    initial begin
        conn_open = '0;
        conn_close = 1'b0;
        conn_timeout = 1'b0;
        cyc = '0;
    end
    task automatic open_conn(input logic [15:0] asm, input logic [15:0] len, input logic [31:0] unit,
            input logic [31:0] cal, input logic [31:0] safe);
        @(posedge mclk);
        conn_open <= '{1'b1, asm, len, unit, cal, safe};
        @(posedge mclk);
        conn_open <= '{1'b0, ~asm, ~len, ~unit, ~cal, ~safe};
    endtask
    task automatic send(input logic run, input logic [15:0] asm, input logic [31:0] sel);
        @(posedge mclk);
        cyc <= '{1'b1, asm, run, sel};
        @(posedge mclk);
        cyc <= '{1'b0, ~asm, ~run, ~sel};
    endtask
    task automatic drop(input logic tmo);
        @(posedge mclk);
        conn_close <= !tmo;
        conn_timeout <= tmo;
        @(posedge mclk);
        conn_close <= 1'b0;
        conn_timeout <= 1'b0;
    endtask
endmodule

/* test/testbench.sv */
// Self-checking bench for the safe mode supervisor
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import fcsms_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] err_status = 32'h0;
    logic [31:0] warn_status = 32'h0;
    logic [15:0] valve_pos = 16'h5A5A;
    logic [31:0] rdata, active_cal;
    fcsms_open_t conn_open;
    fcsms_cyc_t cyc;
    logic conn_close, conn_timeout, conn_accept, conn_reject, safe_mode, ctrl_run, valve_force;
    logic alarm, warning, irq;
    logic [15:0] valve_cmd, flow_unit, ctrl_unit, temp_unit;
    int fails = 0;
    int compares = 0;
    always #50 mclk = ~mclk;
    fcsms_top u_dut (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .err_status(err_status), .warn_status(warn_status), .valve_pos(valve_pos),
        .conn_open(conn_open), .conn_close(conn_close), .conn_timeout(conn_timeout), .cyc(cyc),
        .conn_accept(conn_accept), .conn_reject(conn_reject), .safe_mode(safe_mode), .ctrl_run(ctrl_run),
        .valve_force(valve_force), .valve_cmd(valve_cmd), .active_cal(active_cal), .flow_unit(flow_unit),
        .ctrl_unit(ctrl_unit), .temp_unit(temp_unit), .alarm(alarm), .warning(warning), .irq(irq));
    fcsms_master u_master (.mclk(mclk), .conn_open(conn_open), .conn_close(conn_close),
        .conn_timeout(conn_timeout), .cyc(cyc));
    task automatic tally_and_finish;
        if (fails == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Bounded wait for the mode to settle
    task automatic wait_mode(input logic exp);
        int n;
        #1;
        for (n = 0; n < 6 && safe_mode !== exp; n++) begin
            tick(1);
        end
        check(safe_mode, exp);
        if (safe_mode !== exp) begin
            tally_and_finish();
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask
    task automatic open_chk(input logic [15:0] asm, input logic [15:0] len, input logic [31:0] unit,
            input logic [31:0] cal, input logic [31:0] safe, input logic acc);
        u_master.open_conn(asm, len, unit, cal, safe);
        #1;
        check(conn_accept, acc);
        check(conn_reject, !acc);
    endtask
    task automatic t_reset;
        check(safe_mode, 1'b1);
        check(valve_cmd, 16'h0000);
        check(alarm, 1'b0);
        rd_chk(FCSMS_A_CTRL, 32'h1);
        rd_chk(FCSMS_A_CAL, 32'h1);
        rd_chk(FCSMS_A_ALARM_MASK, 32'h0);
        rd_chk(FCSMS_A_WARN_MASK, 32'h0);
        rd_chk(FCSMS_A_FLOW_UNIT, 32'h1007);
        rd_chk(FCSMS_A_CTRL_UNIT, 32'h1007);
        rd_chk(FCSMS_A_TEMP_UNIT, 32'h1200);
        rd_chk(8'hFC, 32'h0);
        @(posedge mclk);
        warn_status <= 32'h8;
        #1;
        check(warning, 1'b0);
        wr_reg(FCSMS_A_WARN_MASK, 32'h8);
        #1;
        check(warning, 1'b1);
    endtask
    task automatic t_reject;
        open_chk(FCSMS_ASM_CFG, FCSMS_CFG_LEN, 32'h0FFF, 32'h1, 32'h0, 1'b0);
        open_chk(FCSMS_ASM_CFG, FCSMS_CFG_LEN, 32'h1100, 32'h2, 32'h0, 1'b0);
        open_chk(FCSMS_ASM_CFG, FCSMS_CFG_LEN, 32'h1100, 32'h1, 32'h4, 1'b0);
        rd_chk(FCSMS_A_FLOW_UNIT, 32'h1007);
        check(irq, 1'b0);
        wr_reg(FCSMS_A_IRQ_MASK, 32'h4);
        #1;
        check(irq, 1'b1);
        wr_reg(FCSMS_A_IRQ_STAT, 32'hF);
        #1;
        check(irq, 1'b0);
    endtask
    task automatic t_run;
        wr_reg(FCSMS_A_SAFE_VAL, 32'h1234);
        open_chk(FCSMS_ASM_CFG, FCSMS_CFG_LEN, 32'h1100, 32'h1, 32'h3, 1'b1);
        rd_chk(FCSMS_A_FLOW_UNIT, 32'h1100);
        check(safe_mode, 1'b1);
        u_master.send(1'b1, FCSMS_ASM_OUT_CTRL, 32'h0);
        wait_mode(1'b0);
        check(ctrl_run, 1'b1);
        check(valve_force, 1'b0);
        rd_chk(FCSMS_A_STATUS, 32'h3);
        open_chk(FCSMS_ASM_NONE, FCSMS_CFG_LEN_NONE, 32'h0, 32'h0, 32'h0, 1'b0);
        @(posedge mclk);
        err_status <= 32'h8000_0000;
        wait_mode(1'b1);
        check(valve_force, 1'b1);
        check(valve_cmd, 16'h1234);
        check(ctrl_run, 1'b0);
        rd_chk(FCSMS_A_ERR, 32'h8000_0000);
        @(posedge mclk);
        err_status <= 32'h0;
        wait_mode(1'b0);
        u_master.send(1'b0, FCSMS_ASM_OUT_CTRL, 32'h0);
        wait_mode(1'b1);
        u_master.send(1'b1, FCSMS_ASM_OUT_CTRL, 32'h0);
        wait_mode(1'b0);
        u_master.drop(1'b0);
        wait_mode(1'b1);
        u_master.send(1'b1, FCSMS_ASM_OUT_CTRL, 32'h0);
        tick(3);
        check(safe_mode, 1'b1);
    endtask
    task automatic t_codes;
        logic [15:0] exp_v [4];
        int i;
        exp_v = '{16'h0000, 16'hFFFF, 16'h5A5A, 16'h1234};
        open_chk(FCSMS_ASM_NONE, FCSMS_CFG_LEN_NONE, 32'hFFFF_FFFF, 32'h0, 32'h7, 1'b1);
        u_master.send(1'b1, FCSMS_ASM_OUT_CTRL, 32'h0);
        for (i = 0; i < 4; i++) begin
            wr_reg(FCSMS_A_CTRL, 32'(i * 2 + 1));
            @(posedge mclk);
            err_status <= 32'h0;
            valve_pos <= 16'h5A5A;
            wait_mode(1'b0);
            tick(1);
            check(valve_cmd, 16'h5A5A);
            @(posedge mclk);
            err_status <= 32'h1;
            wait_mode(1'b1);
            @(posedge mclk);
            valve_pos <= 16'hC3C3;
            tick(2);
            check(valve_cmd, exp_v[i]);
        end
        @(posedge mclk);
        err_status <= 32'h0;
        wait_mode(1'b0);
    endtask
    task automatic t_cal;
        wr_reg(FCSMS_A_NUM_CAL, 32'h3);
        u_master.send(1'b1, FCSMS_ASM_OUT_CTRL, 32'h3);
        #1;
        check(active_cal, 32'h3);
        u_master.send(1'b1, FCSMS_ASM_OUT_CTRL, 32'h0);
        #1;
        check(active_cal, 32'h3);
        u_master.send(1'b1, FCSMS_ASM_OUT_CTRL, 32'h4);
        #1;
        check(active_cal, 32'h3);
        rd_chk(FCSMS_A_ALARM, 32'h1);
        check(alarm, 1'b0);
        wr_reg(FCSMS_A_ALARM_MASK, 32'h1);
        #1;
        check(alarm, 1'b1);
        wr_reg(FCSMS_A_CAL, 32'h0);
        rd_chk(FCSMS_A_CAL, 32'h3);
        wr_reg(FCSMS_A_CTRL, 32'h0);
        u_master.send(1'b1, FCSMS_ASM_OUT_CTRL, 32'h1);
        #1;
        check(active_cal, 32'h3);
        u_master.send(1'b1, FCSMS_ASM_OUT_METER, 32'h1);
        #1;
        check(active_cal, 32'h1);
        u_master.drop(1'b1);
        wait_mode(1'b1);
    endtask
    initial begin
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        tick(2);
        t_reset();
        t_reject();
        t_run();
        t_codes();
        t_cal();
        tally_and_finish();
    end
endmodule
